// >>> design/tmr_params.svh
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
// Register byte addresses
`define TMR_OFS_OUT_MODE   8'h00
`define TMR_OFS_CLK_FORCE  8'h04
`define TMR_OFS_COUNT      8'h08
`define TMR_OFS_COMPARE    8'h0c
`define TMR_OFS_STATUS     8'h10
`define TMR_OFS_MASK       8'h14
`define TMR_OFS_PIN_CTRL   8'h18
// Field positions
`define TMR_COM_HI         7
`define TMR_COM_LO         6
`define TMR_WGM1_BIT       3
`define TMR_WGM0_BIT       6
`define TMR_FOC_BIT        7
`define TMR_CS_HI          2
`define TMR_ST_OVF_BIT     0
`define TMR_ST_CMP_BIT     1
`define TMR_PIN_DIR_BIT    0
// Values
`define TMR_MAX            8'hff
`define TMR_BOTTOM         8'h00
`define TMR_RESET_BYTE     8'h00
`define TMR_PRESC_W        10
`endif

// >>> design/tmr_pkg.sv
package tmr_pkg;
    // Waveform modes, encoding equals the two-bit selection
    typedef enum logic [1:0] {
        TMR_NORMAL = 2'b00,
        TMR_PC_PWM = 2'b01,
        TMR_CTC    = 2'b10,
        TMR_FAST   = 2'b11
    } tmr_mode_t;

    // APB request bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } tmr_apb_req_t;

    // Waveform pin bundle
    typedef struct packed {
        logic level;
        logic oe;
        logic connected;
    } tmr_pin_t;
endpackage : tmr_pkg

// >>> design/tmr_timer.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_timer
    import tmr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             compare_output_pin,
    output logic             compare_output_pin_oe,
    output logic             pin_overridden
);

    tmr_apb_req_t req;
    tmr_pin_t     pin;
    logic [1:0]   compare_output_mode;
    tmr_mode_t    waveform_mode_sel;
    logic [2:0]   clock_select_field;
    logic [7:0]   counter_value;
    logic [7:0]   compare_value;
    logic [7:0]   compare_buffer;
    logic [1:0]   status;
    logic [1:0]   mask;
    logic         pin_dir;
    logic         count_down;
    logic         wave;
    logic         block_match;
    logic [`TMR_PRESC_W-1:0] presc;
    logic         tick;
    logic         wr_en;
    logic         is_pwm;
    logic [7:0]   top_val;
    logic         match;
    logic         force_strobe;
    logic         cnt_write;
    logic         ovf_evt;
    logic         cmp_evt;
    logic         at_top;

    // Bundle the bus request
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    // Zero wait state slave; every access completes in its access phase
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = req.sel && req.enable && req.write;
    assign cnt_write = wr_en && (req.addr == `TMR_OFS_COUNT);
    assign force_strobe = wr_en && (req.addr == `TMR_OFS_CLK_FORCE) && req.wdata[`TMR_FOC_BIT];

    assign is_pwm  = waveform_mode_sel == TMR_PC_PWM || waveform_mode_sel == TMR_FAST;
    assign top_val = (waveform_mode_sel == TMR_CTC) ? compare_value : `TMR_MAX;
    assign at_top  = counter_value == top_val;

    // Free-running prescaler; tick picks a tap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    // Tap selection, enable pulse at the chosen rate
    always_comb begin
        case (clock_select_field)
            3'h0:    tick = 1'b0;
            3'h1:    tick = 1'b1;
            3'h2:    tick = presc[2:0] == 3'h7;
            3'h3:    tick = presc[4:0] == 5'h1f;
            3'h4:    tick = presc[5:0] == 6'h3f;
            3'h5:    tick = presc[6:0] == 7'h7f;
            3'h6:    tick = presc[7:0] == 8'hff;
            default: tick = presc == 10'h3ff;
        endcase
    end

    // Match only on a tick, and not right after a counter write
    assign match = tick && !block_match && (counter_value == compare_value);

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_mode <= 2'h0;
            waveform_mode_sel   <= TMR_NORMAL;
            clock_select_field  <= 3'h0;
            mask                <= 2'h0;
            pin_dir             <= 1'b0;
        end else if (wr_en) begin
            case (req.addr)
                `TMR_OFS_OUT_MODE: begin
                    compare_output_mode <= req.wdata[`TMR_COM_HI:`TMR_COM_LO];
                    waveform_mode_sel   <= tmr_mode_t'({req.wdata[`TMR_WGM1_BIT], req.wdata[`TMR_WGM0_BIT]});
                end
                `TMR_OFS_CLK_FORCE: clock_select_field <= req.wdata[`TMR_CS_HI:0];
                `TMR_OFS_MASK:      mask               <= req.wdata[1:0];
                `TMR_OFS_PIN_CTRL:  pin_dir            <= req.wdata[`TMR_PIN_DIR_BIT];
                default: ;
            endcase
        end
    end

    // Compare value: buffer written by software, active copy loaded per mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_buffer <= `TMR_RESET_BYTE;
            compare_value  <= `TMR_RESET_BYTE;
        end else begin
            if (wr_en && req.addr == `TMR_OFS_COMPARE) begin
                compare_buffer <= req.wdata[7:0];
            end
            if (!is_pwm) begin
                compare_value <= (wr_en && req.addr == `TMR_OFS_COMPARE) ? req.wdata[7:0] : compare_buffer;
            end else if (tick && at_top) begin
                compare_value <= compare_buffer;
            end
        end
    end

    // Counter and direction; a bus write always wins over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= `TMR_RESET_BYTE;
            count_down    <= 1'b0;
        end else if (cnt_write) begin
            counter_value <= req.wdata[7:0];
        end else if (tick) begin
            case (waveform_mode_sel)
                TMR_PC_PWM: begin
                    if (!count_down && counter_value == `TMR_MAX) begin
                        count_down    <= 1'b1;
                        counter_value <= counter_value - 8'h01;
                    end else if (count_down && counter_value == `TMR_BOTTOM) begin
                        count_down    <= 1'b0;
                        counter_value <= counter_value + 8'h01;
                    end else begin
                        counter_value <= count_down ? counter_value - 8'h01 : counter_value + 8'h01;
                    end
                end
                TMR_CTC: begin
                    count_down    <= 1'b0;
                    counter_value <= at_top ? `TMR_BOTTOM : counter_value + 8'h01;
                end
                default: begin
                    count_down    <= 1'b0;
                    counter_value <= counter_value + 8'h01;
                end
            endcase
        end
    end

    // Block one tick's match after a counter write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_match <= 1'b0;
        end else if (cnt_write) begin
            block_match <= 1'b1;
        end else if (tick) begin
            block_match <= 1'b0;
        end
    end

    // Overflow: at MAX, or at BOTTOM turnaround in phase-correct
    assign ovf_evt = tick && ((waveform_mode_sel == TMR_PC_PWM) ?
                     (count_down && counter_value == `TMR_BOTTOM) : counter_value == `TMR_MAX);
    // A forced match never reaches the flag
    assign cmp_evt = match;

    // Sticky flags; a set in the same cycle beats a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `TMR_ST_OVF_BIT) ? ovf_evt : cmp_evt) begin
                    status[i] <= 1'b1;
                end else if (wr_en && req.addr == `TMR_OFS_STATUS && req.wdata[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(status & mask);

    // Waveform generator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave <= 1'b0;
        end else if (!is_pwm) begin
            if (match || (force_strobe)) begin
                case (compare_output_mode)
                    2'b01:   wave <= ~wave;
                    2'b10:   wave <= 1'b0;
                    2'b11:   wave <= 1'b1;
                    default: wave <= wave;
                endcase
            end
        end else if (compare_output_mode[1] && tick) begin
            // Compare at TOP: the top action replaces the match
            if (compare_value == `TMR_MAX && counter_value == `TMR_MAX) begin
                wave <= ~compare_output_mode[0];
            end else if (waveform_mode_sel == TMR_FAST) begin
                if (match && compare_value != `TMR_MAX) begin
                    wave <= compare_output_mode[0];
                end else if (counter_value == `TMR_MAX) begin
                    wave <= ~compare_output_mode[0];
                end
            end else if (match && compare_value != `TMR_MAX) begin
                wave <= count_down ? ~compare_output_mode[0] : compare_output_mode[0];
            end
        end
    end

    // Pin override: PWM modes need the upper bit; direction gates the driver
    assign pin.connected = is_pwm ? compare_output_mode[1] : (compare_output_mode != 2'h0);
    assign pin.level     = wave;
    assign pin.oe        = pin.connected && pin_dir;
    assign compare_output_pin    = pin.level;
    assign compare_output_pin_oe = pin.oe;
    assign pin_overridden        = pin.connected;

    // Read mux; reserved bits and the strobe read zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (req.sel && !req.write) begin
            case (req.addr)
                `TMR_OFS_OUT_MODE: begin
                    prdata[`TMR_COM_HI:`TMR_COM_LO] = compare_output_mode;
                    prdata[`TMR_WGM1_BIT]           = waveform_mode_sel[1];
                end
                `TMR_OFS_CLK_FORCE: prdata[`TMR_CS_HI:0] = clock_select_field;
                `TMR_OFS_COUNT:     prdata[7:0] = counter_value;
                `TMR_OFS_COMPARE:   prdata[7:0] = compare_buffer;
                `TMR_OFS_STATUS:    prdata[1:0] = status;
                `TMR_OFS_MASK:      prdata[1:0] = mask;
                `TMR_OFS_PIN_CTRL:  prdata[0]   = pin_dir;
                default:            prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule : tmr_timer

// >>> verif/tmr_timer_chk.sv
`timescale 1ns/1ps
module tmr_timer_chk
    import tmr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        irq,
    input wire logic        compare_output_pin,
    input wire logic        compare_output_pin_oe,
    input wire logic        pin_overridden
);
    logic [2:0] cs;
    logic [1:0] msk;
    logic [7:0] cnt;
    logic       cnt_ok;
    logic       quiet;
    wire        wr = psel && penable && pready && pwrite;
    wire        rd = psel && penable && pready && !pwrite;
    // Write shadows; count is only known while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cs, msk, cnt, quiet} <= '0;
            cnt_ok <= 1'b1;
        end else begin
            if (wr && paddr == 8'h04) cs <= pwdata[2:0];
            if (wr && paddr == 8'h14) msk <= pwdata[1:0];
            if (wr && paddr == 8'h08) cnt <= pwdata[7:0];
            if (wr && paddr == 8'h08) cnt_ok <= cs == 3'h0;
            else if (wr && paddr == 8'h04 && pwdata[2:0] != 3'h0) cnt_ok <= 1'b0;
            quiet <= cs == 3'h0 && !wr;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_oe_needs_ovr: assert property (compare_output_pin_oe |-> pin_overridden)
        else $error("pin driven without override");
    a_com_off_frees: assert property (wr && paddr == 8'h00 && pwdata[7:6] == 2'b00
        |=> !pin_overridden && !compare_output_pin_oe) else $error("pin still overridden");
    a_com_on_takes: assert property (wr && paddr == 8'h00 && pwdata[7] |=> pin_overridden)
        else $error("pin not overridden");
    a_clk_readback: assert property (rd && paddr == 8'h04 |-> prdata == {29'h0, cs})
        else $error("clock control read wrong");
    a_ctrl_rsvd_zero: assert property (rd && paddr == 8'h00 |-> (prdata & 32'hffff_ff37) == '0)
        else $error("reserved control bits set");
    a_count_direct: assert property (rd && paddr == 8'h08 && cnt_ok |-> prdata == {24'h0, cnt})
        else $error("count read wrong");
    a_mask_gates_irq: assert property (msk == 2'b00 |-> !irq)
        else $error("irq with all masked");
    a_pin_stopped: assert property (quiet |-> $stable(compare_output_pin))
        else $error("pin moved while stopped");
endmodule : tmr_timer_chk

bind tmr_timer tmr_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .irq(irq),
    .compare_output_pin(compare_output_pin), .compare_output_pin_oe(compare_output_pin_oe),
    .pin_overridden(pin_overridden));

// >>> verif/tmr_timer_tb.sv
`timescale 1ns/1ps
module tmr_timer_tb
    import tmr_pkg::*;
;
    tmr_apb_req_t req;
    logic         pclk, presetn, pready, pslverr, irq, pin, oe, ovr;
    logic [31:0]  prdata, q;
    int           miscompares, n_compared, i;
    int           dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    tmr_timer dut (.pclk(pclk), .presetn(presetn), .psel(req.sel), .penable(req.enable), .pwrite(req.write),
        .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .compare_output_pin(pin), .compare_output_pin_oe(oe), .pin_overridden(ovr));
    // Bus clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One transfer; ends on a falling edge so outputs have settled
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.enable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        req <= '0;
        @(negedge pclk);
    endtask : xfer
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(q, e);
        check({31'h0, pslverr}, 0);
    endtask : rd
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // Watchdog well above the prescaler sweep
    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        finish_test();
    end
    initial begin
        req = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // All zero from reset, unmapped word included
        for (i = 0; i < 8; i++) rd(8'(i * 4), 0);
        xfer(1, 8'h04, '1);
        rd(8'h04, 32'h07);
        xfer(1, 8'h00, '1);
        rd(8'h00, 32'hc8);
        xfer(1, 8'h04, 0);
        xfer(1, 8'h08, 32'h5a);
        rd(8'h08, 32'h5a);
        xfer(1, 8'h00, 0);
        xfer(1, 8'h0c, 32'h80);
        $display("test access done");
        // Overflow flag, masking and write-one clear
        xfer(1, 8'h14, 1);
        xfer(1, 8'h08, 32'hf0);
        xfer(1, 8'h04, 1);
        for (i = 0; i < 60 && irq !== 1'b1; i++) @(posedge pclk);
        xfer(1, 8'h04, 0);
        rd(8'h10, 32'h1);
        check({31'h0, irq}, 1);
        xfer(1, 8'h14, 0);
        check({31'h0, irq}, 0);
        xfer(1, 8'h10, 1);
        rd(8'h10, 0);
        // Match on compare value sets its own flag only
        xfer(1, 8'h14, 2);
        xfer(1, 8'h08, 0);
        xfer(1, 8'h04, 1);
        for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge pclk);
        xfer(1, 8'h04, 0);
        rd(8'h10, 32'h2);
        $display("test flags done");
        // Clear-on-match wraps before ever reaching the overflow
        xfer(1, 8'h00, 8);
        xfer(1, 8'h0c, 5);
        xfer(1, 8'h08, 0);
        xfer(1, 8'h10, 3);
        xfer(1, 8'h04, 1);
        repeat (300) @(posedge pclk);
        xfer(1, 8'h04, 0);
        xfer(0, 8'h08, 0);
        check({31'h0, q <= 5}, 1);
        rd(8'h10, 32'h2);
        $display("test wrap done");
        // Prescaler taps: four periods give four ticks, phase adds one at most
        xfer(1, 8'h00, 0);
        for (i = 2; i < 8; i++) begin
            xfer(1, 8'h08, 0);
            xfer(1, 8'h04, i);
            repeat (4 * dv[i]) @(posedge pclk);
            xfer(1, 8'h04, 0);
            xfer(0, 8'h08, 0);
            check({31'h0, q >= 3 && q <= 5}, 1);
        end
        $display("test prescale done");
        // Fast PWM sets on match; strobe ignored there, acts in normal mode
        xfer(1, 8'h18, 1);
        xfer(1, 8'h00, 32'hc8);
        xfer(1, 8'h0c, 32'h80);
        xfer(1, 8'h04, 1);
        for (i = 0; i < 600 && pin !== 1'b1; i++) @(posedge pclk);
        xfer(1, 8'h04, 0);
        check({29'h0, pin, oe, ovr}, 7);
        xfer(1, 8'h04, 32'h80);
        check({31'h0, pin}, 1);
        xfer(1, 8'h10, 3);
        xfer(1, 8'h00, 32'h80);
        xfer(1, 8'h04, 32'h80);
        check({31'h0, pin}, 0);
        rd(8'h10, 0);
        xfer(1, 8'h00, 0);
        check({30'h0, oe, ovr}, 0);
        // Fast PWM with compare at TOP: match ignored, top action leaves pin low
        xfer(1, 8'h00, 32'hc8);
        xfer(1, 8'h0c, 32'hff);
        xfer(1, 8'h08, 32'h10);
        xfer(1, 8'h04, 1);
        repeat (600) @(posedge pclk);
        xfer(1, 8'h04, 0);
        check({31'h0, pin}, 0);
        xfer(1, 8'h00, 0);
        $display("test pin done");
        finish_test();
    end
endmodule : tmr_timer_tb
